// file: hw/pldsec_ctrl.sv
/*
 * Control of macrocell registers: power-up reset, sleep hold, preload,
 * security fuse, signature access and pin keepers.
 * Assumes pins arrive asynchronously and are synchronised here; the
 * user logic array supplies next cell values and enables on ref_clk.
 */
module pldsec_ctrl #(
   parameter int N = pldsec_pkg::NUM_CELLS
) (
   input wire logic ref_clk, // device clock
   input wire logic rstn, // power-up reset, active low
   input wire logic sleep_hold_input, // power-down pin, async
   input wire logic [N-1:0] logic_next, // array next register values
   input wire logic [N-1:0] logic_oe, // array output enables
   input wire logic [N-1:0] out_invert, // per-output polarity
   input wire logic [N-1:0] pin_in, // pad input level
   input wire logic [N-1:0] pin_drv, // pad has an external driver
   input wire logic preload_req, // preload strobe
   input wire logic [N-1:0] preload_val, // preload values
   input wire logic verify_req, // config readback request
   input wire logic [N-1:0] verify_data, // config pattern to read
   input wire logic fuse_prog, // program the security fuse
   input wire logic sig_we, // signature write
   input wire logic [pldsec_pkg::SIG_ADDR_W-1:0] sig_addr, // signature addr
   input wire logic [pldsec_pkg::SIG_DATA_W-1:0] sig_wdata, // sig data
   output logic [N-1:0] pin_o_ff, // pad output level
   output logic [N-1:0] pin_oe_ff, // pad output enable
   output logic [N-1:0] pin_keep_ff, // kept pad level to array
   output logic [N-1:0] cell_q_ff, // macrocell registers
   output logic [N-1:0] verify_out_ff, // readback data, zeroed by a verify while secured
   output logic secured_ff, // fuse programmed
   output logic refused_ff, // last verify or preload refused
   output logic sleeping_ff, // in sleep hold
   output logic ready_ff, // power-up reset over
   output logic [pldsec_pkg::SIG_DATA_W-1:0] sig_rdata_ff // sig read data
);
   pldsec_pkg::pldsec_state_e state_ff, nxt_state;
   logic [2:0] slp_sync_ff;
   logic slp_ff;
   logic [pldsec_pkg::PUR_CNT_W-1:0] pur_cnt_ff;
   logic run;
   logic [2:0][2*N-1:0] pad_sync_ff;
   logic [2*N-1:0] pad_ff;

   // three stages; change counts when second and third agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         slp_sync_ff <= '0;
      end else begin
         slp_sync_ff <= {slp_sync_ff[1:0], sleep_hold_input};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         slp_ff <= 1'b0;
      end else if (slp_sync_ff[1] == slp_sync_ff[2]) begin
         slp_ff <= slp_sync_ff[2];
      end
   end

   // pads are async too; driver flag and level share one pipe so they
   // stay aligned when a driver lets go
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pad_sync_ff <= '0;
      end else begin
         pad_sync_ff <= {pad_sync_ff[1:0], pin_drv, pin_in};
      end
   end

   // a bit counts once second and third stage agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pad_ff <= '0;
      end else begin
         pad_ff <= (pad_sync_ff[2] & ~(pad_sync_ff[1] ^ pad_sync_ff[2])) |
            (pad_ff & (pad_sync_ff[1] ^ pad_sync_ff[2]));
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pldsec_pkg::ST_PUR: begin
            if (pur_cnt_ff ==
                pldsec_pkg::PUR_CNT_W'(pldsec_pkg::PUR_CYC - 1)) begin
               nxt_state = pldsec_pkg::ST_RUN;
            end
         end
         pldsec_pkg::ST_RUN: begin
            if (slp_ff) begin
               nxt_state = pldsec_pkg::ST_SLEEP;
            end
         end
         pldsec_pkg::ST_SLEEP: begin
            if (!slp_ff) begin
               nxt_state = pldsec_pkg::ST_RUN;
            end
         end
         default: nxt_state = pldsec_pkg::ST_PUR;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= pldsec_pkg::ST_PUR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // counts out the reset interval before the array may clock
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pur_cnt_ff <= '0;
      end else if (state_ff == pldsec_pkg::ST_PUR) begin
         pur_cnt_ff <= pur_cnt_ff + 1'b1;
      end
   end

   // run also requires no sleep request this cycle, so no edge slips in
   assign run = (state_ff == pldsec_pkg::ST_RUN) && !slp_ff;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sleeping_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         sleeping_ff <= (nxt_state == pldsec_pkg::ST_SLEEP);
         ready_ff <= (nxt_state != pldsec_pkg::ST_PUR);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         secured_ff <= 1'b0;
      end else if (fuse_prog) begin
         secured_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cell_q_ff <= {N{pldsec_pkg::CELL_RESET}};
      end else if (preload_req && !secured_ff && !fuse_prog) begin
         cell_q_ff <= preload_val;
      end else if (run) begin
         cell_q_ff <= logic_next;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         verify_out_ff <= '0;
         refused_ff <= 1'b0;
      end else begin
         if (verify_req) begin
            verify_out_ff <= (secured_ff || fuse_prog) ? '0 : verify_data;
         end
         if (verify_req || preload_req) begin
            refused_ff <= secured_ff || fuse_prog;
         end
      end
   end

   // output stage; enables updated only when running
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_oe_ff <= '0;
      end else if (run) begin
         pin_oe_ff <= logic_oe;
      end
   end

   // held because the update is gated off while state_ff is ST_SLEEP
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_o_ff <= '0;
      end else if (state_ff != pldsec_pkg::ST_SLEEP) begin
         pin_o_ff <= cell_q_ff ^ out_invert;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_keep
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               pin_keep_ff[g] <= 1'b0;
            end else if (pin_oe_ff[g]) begin
               pin_keep_ff[g] <= pin_o_ff[g];
            end else if (pad_ff[N+g] && state_ff != pldsec_pkg::ST_SLEEP) begin
               pin_keep_ff[g] <= pad_ff[g];
            end
         end
      end
   endgenerate

   pldsec_sig_mem u_sig (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .we(sig_we),
      .addr(sig_addr),
      .wdata(sig_wdata),
      .rdata_ff(sig_rdata_ff)
   );

   sleep_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_ff == pldsec_pkg::ST_SLEEP && $past(state_ff) ==
       pldsec_pkg::ST_SLEEP) |-> $stable(pin_o_ff))
      else $error("output changed during sleep");
   hiz_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      sleeping_ff |=> $stable(pin_oe_ff))
      else $error("enable changed during sleep");
   cell_freeze_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (sleeping_ff && !preload_req) |=> $stable(cell_q_ff))
      else $error("register moved during sleep");
   pur_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !ready_ff |-> (cell_q_ff == '0 || $past(preload_req)))
      else $error("register not clear in reset");
   pol_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_ff != pldsec_pkg::ST_SLEEP) |=>
      pin_o_ff == ($past(cell_q_ff) ^ $past(out_invert)))
      else $error("output polarity wrong");
   preload_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (preload_req && !secured_ff && !fuse_prog) |=>
      cell_q_ff == $past(preload_val))
      else $error("preload not taken");
   sequence sig_wr_s;
      (sig_we && secured_ff) ##1 (sig_addr == $past(sig_addr));
   endsequence
   sig_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      sig_wr_s |=> sig_rdata_ff == $past(sig_wdata, 2))
      else $error("signature not writable when secured");
   fuse_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (secured_ff && verify_req) |=> verify_out_ff == '0 && refused_ff)
      else $error("readback not blocked");
   keep_pin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!pin_oe_ff[0] && !pad_ff[N]) |=> $stable(pin_keep_ff[0]))
      else $error("keeper lost value");
   wake_run_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_ff == pldsec_pkg::ST_SLEEP && !slp_ff) |=>
      state_ff == pldsec_pkg::ST_RUN)
      else $error("no resume after release");
endmodule

// file: hw/pldsec_pkg.sv
/*
 * Shared constants for the power-down, power-up reset, preload,
 * signature and security control block of a small registered logic device.
 * Assumes a single 40 MHz ref_clk and an asynchronous active-low reset.
 */
package pldsec_pkg;
   localparam int CLK_PERIOD_NS = 25;
   // power_up_reset_time, typical and longest
   localparam int PUR_TYP_NS = 600;
   localparam int PUR_MAX_NS = 1000;
   // typical time: round up
   localparam int PUR_CYC = (PUR_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PUR_CNT_W = 6;
   localparam int NUM_CELLS = 10;
   localparam int SIG_WORDS = 8;
   localparam int SIG_ADDR_W = 3;
   localparam int SIG_DATA_W = 8;
   localparam logic [SIG_DATA_W-1:0] SIG_RESET = 8'h00;
   localparam logic CELL_RESET = 1'b0;
   typedef enum logic [1:0] {
      ST_PUR,
      ST_RUN,
      ST_SLEEP
   } pldsec_state_e;
endpackage

// file: hw/pldsec_sig_mem.sv
/*
 * User signature store: 64 bits as 8 words of 8 bits, registered read.
 * The caller passes writes ungated; reads are never blocked.
 */
module pldsec_sig_mem #(
   parameter int AW = pldsec_pkg::SIG_ADDR_W,
   parameter int DW = pldsec_pkg::SIG_DATA_W
) (
   input wire logic ref_clk, // clock
   input wire logic rstn, // async reset, active low
   input wire logic we, // write strobe
   input wire logic [AW-1:0] addr, // word address
   input wire logic [DW-1:0] wdata, // write data
   output logic [DW-1:0] rdata_ff // registered read data
);
   logic [DW-1:0] mem_ff [2**AW];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 2**AW; i++) begin
            mem_ff[i] <= pldsec_pkg::SIG_RESET;
         end
      end else if (we) begin
         mem_ff[addr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= pldsec_pkg::SIG_RESET;
      end else begin
         rdata_ff <= mem_ff[addr];
      end
   end
endmodule

// file: tb/pldsec_board.sv
/*
 * Board-side model: drives the power-down pin, array values and pads.
 * Assumes the bench gives wanted levels just after each rising edge.
 */
module pldsec_board #(
   parameter int N = pldsec_pkg::NUM_CELLS
) (
   input wire logic ref_clk, // device clock
   input wire logic ready, // power-up reset over
   input wire logic want_sleep, // wanted sleep level
   input wire logic [N-1:0] want_next, // wanted array values
   input wire logic [N-1:0] want_oe, // wanted enables
   input wire logic [N-1:0] want_pin, // wanted pad levels
   input wire logic [N-1:0] want_drv, // pads driven by board
   output logic sleep_hold_input, // power-down pin
   output logic [N-1:0] logic_next, // array next values
   output logic [N-1:0] logic_oe, // array enables
   output logic [N-1:0] pin_in, // pad levels
   output logic [N-1:0] pin_drv // driver present
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [N-1:0] pin_last = 10'h000;
   assign sleep_hold_input = want_sleep;
   assign logic_oe = want_oe;
   assign pin_drv = want_drv;
   assign logic_next = ready ? want_next : 10'h000;
   assign pin_in = (want_drv & want_pin) | (~want_drv & ~pin_last);
   always @(posedge ref_clk) begin
      pin_last <= pin_in;
   end
endmodule

// file: tb/testbench.sv
/*
 * Self-checking bench for the macrocell control block.
 * Assumes the board model and the design with its own assertions.
 */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int N = pldsec_pkg::NUM_CELLS;
   localparam logic [N-1:0] INV = 10'h2AA;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic want_sleep = 1'b0;
   logic [N-1:0] want_next = 10'h000, want_oe = 10'h000;
   logic [N-1:0] want_pin = 10'h000, want_drv = 10'h000;
   logic preload_req = 1'b0, verify_req = 1'b0;
   logic fuse_prog = 1'b0, sig_we = 1'b0;
   logic [N-1:0] preload_val = 10'h000, verify_data = 10'h000;
   logic [2:0] sig_addr = 3'h0;
   logic [7:0] sig_wdata = 8'h00;
   logic sleep_hold_input, secured, refused, sleeping, ready;
   logic [N-1:0] logic_next, logic_oe, pin_in, pin_drv, pin_o, pin_oe;
   logic [N-1:0] pin_keep, cell_q, verify_out, exp_keep, pv;
   logic [7:0] sig_rdata;
   int bad_count = 0, tests_run = 0, n;

   always #12.5 ref_clk = ~ref_clk;

   pldsec_board u_pldsec_board (.ref_clk(ref_clk), .ready(ready),
      .want_sleep(want_sleep), .want_next(want_next), .want_oe(want_oe),
      .want_pin(want_pin), .want_drv(want_drv),
      .sleep_hold_input(sleep_hold_input), .logic_next(logic_next),
      .logic_oe(logic_oe), .pin_in(pin_in), .pin_drv(pin_drv));

   pldsec_ctrl u_pldsec_ctrl (.ref_clk(ref_clk), .rstn(rstn),
      .sleep_hold_input(sleep_hold_input), .logic_next(logic_next),
      .logic_oe(logic_oe), .out_invert(INV), .pin_in(pin_in),
      .pin_drv(pin_drv), .preload_req(preload_req),
      .preload_val(preload_val), .verify_req(verify_req),
      .verify_data(verify_data), .fuse_prog(fuse_prog), .sig_we(sig_we),
      .sig_addr(sig_addr), .sig_wdata(sig_wdata), .pin_o_ff(pin_o),
      .pin_oe_ff(pin_oe), .pin_keep_ff(pin_keep), .cell_q_ff(cell_q),
      .verify_out_ff(verify_out), .secured_ff(secured),
      .refused_ff(refused), .sleeping_ff(sleeping), .ready_ff(ready),
      .sig_rdata_ff(sig_rdata));

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wait_sleep(input logic lvl);
      n = 0;
      while (sleeping !== lvl && n < 12) begin
         cyc(1);
         n++;
      end
      chk(sleeping, lvl);
   endtask
   task automatic preload(input logic [N-1:0] v);
      preload_val = v;
      preload_req = 1'b1;
      cyc(1);
      preload_req = 1'b0;
   endtask
   task automatic verify(input logic [N-1:0] d, e, input logic r);
      verify_data = d;
      verify_req = 1'b1;
      cyc(1);
      verify_req = 1'b0;
      chk(verify_out, e);
      chk(refused, r);
   endtask
   task automatic sig_rd(input logic [2:0] a, input logic [7:0] e);
      sig_addr = a;
      cyc(1);
      chk(sig_rdata, e);
   endtask

   initial begin
      #(1000 * 25);
      bad_count++;
      end_of_test();
   end

   initial begin
      cyc(4);
      rstn = 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk(n, pldsec_pkg::PUR_CYC);
      chk(cell_q, 10'h000);
      chk(pin_o, INV);
      for (int i = 0; i < 2; i++) begin
         pv = i ? ~10'h3C5 : 10'h3C5;
         preload(pv);
         chk(cell_q, pv);
         cyc(1);
         chk(pin_o, pv ^ INV);
      end
      want_next = 10'h155;
      want_oe = 10'h0F0;
      want_drv = 10'h3FF;
      want_pin = 10'h30C;
      // pads pass three sync stages and the agree filter
      cyc(5);
      chk(cell_q, 10'h155);
      chk(pin_oe, 10'h0F0);
      chk(pin_o, 10'h155 ^ INV);
      exp_keep = ((10'h155 ^ INV) & 10'h0F0) | (10'h30C & ~10'h0F0);
      chk(pin_keep, exp_keep);
      want_drv = 10'h000;
      cyc(4);
      chk(pin_keep, exp_keep);
      want_sleep = 1'b1;
      wait_sleep(1'b1);
      want_next = 10'h2B4;
      want_oe = 10'h30F;
      want_drv = 10'h3FF;
      want_pin = 10'h0F3;
      cyc(6);
      chk(cell_q, 10'h155);
      chk(pin_o, 10'h155 ^ INV);
      chk(pin_oe, 10'h0F0);
      chk(pin_keep, exp_keep);
      want_sleep = 1'b0;
      wait_sleep(1'b0);
      cyc(2);
      chk(cell_q, 10'h2B4);
      chk(pin_oe, 10'h30F);
      sig_we = 1'b1;
      for (int i = 0; i < 8; i++) begin
         sig_addr = i[2:0];
         sig_wdata = 8'h5A ^ (8'h13 * i[7:0]);
         cyc(1);
      end
      sig_we = 1'b0;
      for (int i = 0; i < 8; i++) begin
         sig_rd(i[2:0], 8'h5A ^ (8'h13 * i[7:0]));
      end
      verify(10'h2A5, 10'h2A5, 1'b0);
      fuse_prog = 1'b1;
      cyc(1);
      fuse_prog = 1'b0;
      chk(secured, 1'b1);
      verify(10'h2A5, 10'h000, 1'b1);
      preload(10'h3C5);
      chk(cell_q, 10'h2B4);
      chk(refused, 1'b1);
      sig_addr = 3'h3;
      sig_wdata = 8'hC3;
      sig_we = 1'b1;
      cyc(1);
      sig_we = 1'b0;
      sig_rd(3'h3, 8'hC3);
      sig_rd(3'h5, 8'h5A ^ 8'h5F);
      end_of_test();
   end
endmodule
